// ---- rtl/tsacq_top.sv ----
// Trigger, time-stamp and record acquisition control with APB registers
// Overview of operation
// - Level trigger above or below threshold
// - External trigger from channel A or backplane
// - Software trigger command fires a trigger
// - Records start programmable samples before trigger
// - Pre-trigger may reach the record length, up to PRE_DEPTH - 1 samples
// - Programmable delay before record collection
// - One contiguous record per accepted trigger
// - Stop after record count or run unlimited
// - Latch time-stamp at each accepted trigger
// - Sync input edge resets time-stamp counter
// - Sync output broadcasts the trigger
// - Sync pin may be high impedance
// - Sync chained through all units
// - Channel A trigger interpolated to 25 ps
// - Gain and offset right after conversion
// - Sample skip keeps every Nth sample
// - Sample clock reference is selectable
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "tsacq_map.svh"
module tsacq_top import tsacq_pkg::*; #(
	parameter int ADC_W = 10,
	parameter int PRE_DEPTH = 64,
	parameter int TS_W = 48
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [ADC_W-1:0] adc_data,
	input wire logic [ADC_W-1:0] chan_a_data,
	input wire logic adc_valid,
	output logic adc_ready,
	input wire logic bp_trig,
	input wire logic sync_i,
	output logic sync_o,
	output logic sync_oe,
	output logic [1:0] ref_sel,
	input wire logic pll_locked,
	output logic [15:0] rec_data,
	output logic rec_first,
	output logic rec_last,
	output logic rec_valid,
	input wire logic rec_ready
);
	localparam int AW = $clog2(PRE_DEPTH);
	localparam logic [15:0] PRE_MAX = 16'(PRE_DEPTH - 1);

	tsacq_strm_if #(.W(18)) core_s ();
	tsacq_strm_if #(.W(18)) out_s ();

	logic [31:0] ctrl_reg;
	logic [15:0] level_reg;
	logic [15:0] extlvl_reg;
	logic [15:0] gain_reg;
	logic [15:0] offs_reg;
	logic [15:0] pre_reg;
	logic [15:0] dly_reg;
	logic [15:0] len_reg;
	logic [15:0] nrec_reg;
	logic [15:0] skip_reg;
	logic [TS_W-1:0] ts_reg;
	logic [TS_W-1:0] ts_lat_reg;
	logic [8:0] frac_reg;
	logic [15:0] done_reg;
	logic [31:0] rdata_next;
	logic addr_ok;
	logic apb_wr;
	logic cmd_wr;

	assign apb_wr = psel && penable && pready && pwrite;
	assign cmd_wr = apb_wr && paddr == `TSACQ_CMD_OFS;

	// APB slave: no wait states, error on unmapped address
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else if (psel && !penable) begin
			pready <= 1'b1;
			pslverr <= !addr_ok;
			prdata <= rdata_next;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= 32'h0;
			level_reg <= 16'h0;
			extlvl_reg <= 16'h0;
			gain_reg <= `TSACQ_GAIN_RST;
			offs_reg <= 16'h0;
			pre_reg <= 16'h0;
			dly_reg <= 16'h0;
			len_reg <= `TSACQ_LEN_RST;
			nrec_reg <= 16'h0;
			skip_reg <= 16'h0;
		end else if (apb_wr && !pslverr) begin
			case (paddr)
				`TSACQ_CTRL_OFS: ctrl_reg <= {24'h0, pwdata[7:0]};
				`TSACQ_LEVEL_OFS: level_reg <= pwdata[15:0];
				`TSACQ_EXTLVL_OFS: extlvl_reg <= pwdata[15:0];
				`TSACQ_GAIN_OFS: gain_reg <= pwdata[15:0];
				`TSACQ_OFFS_OFS: offs_reg <= pwdata[15:0];
				// Longest look-back is one less than the history depth
				`TSACQ_PRE_OFS: pre_reg <= (pwdata[15:0] > PRE_MAX) ?
					PRE_MAX : pwdata[15:0];
				`TSACQ_DLY_OFS: dly_reg <= pwdata[15:0];
				`TSACQ_LEN_OFS: len_reg <= pwdata[15:0];
				`TSACQ_NREC_OFS: nrec_reg <= pwdata[15:0];
				`TSACQ_SKIP_OFS: skip_reg <= pwdata[15:0];
				default: begin
				end
			endcase
		end
	end

	tsacq_state_t st_reg;

	always_comb begin
		rdata_next = 32'h0;
		addr_ok = 1'b1;
		case (paddr)
			`TSACQ_CTRL_OFS: rdata_next = ctrl_reg;
			`TSACQ_LEVEL_OFS: rdata_next = {16'h0, level_reg};
			`TSACQ_EXTLVL_OFS: rdata_next = {16'h0, extlvl_reg};
			`TSACQ_GAIN_OFS: rdata_next = {16'h0, gain_reg};
			`TSACQ_OFFS_OFS: rdata_next = {16'h0, offs_reg};
			`TSACQ_PRE_OFS: rdata_next = {16'h0, pre_reg};
			`TSACQ_DLY_OFS: rdata_next = {16'h0, dly_reg};
			`TSACQ_LEN_OFS: rdata_next = {16'h0, len_reg};
			`TSACQ_NREC_OFS: rdata_next = {16'h0, nrec_reg};
			`TSACQ_SKIP_OFS: rdata_next = {16'h0, skip_reg};
			`TSACQ_STAT_OFS: begin
				rdata_next[`TSACQ_STAT_BUSY] = st_reg != TSACQ_IDLE;
				rdata_next[`TSACQ_STAT_LOCK] = pll_locked;
				rdata_next[`TSACQ_STAT_CNT] = done_reg;
			end
			`TSACQ_TSLO_OFS: rdata_next = ts_lat_reg[31:0];
			`TSACQ_TSHI_OFS: rdata_next = 32'(ts_lat_reg[TS_W-1:32]);
			`TSACQ_FRAC_OFS: rdata_next = {23'h0, frac_reg};
			`TSACQ_CMD_OFS: rdata_next = 32'h0;
			default: addr_ok = 1'b0;
		endcase
	end

	// Reference selection goes to the clock generator through one register stage
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_sel <= 2'h0;
		end else begin
			ref_sel <= ctrl_reg[`TSACQ_CTRL_REF];
		end
	end

	// Sample pipeline: stage one holds while the buffer is full
	logic in_rdy;
	logic s2;
	logic proc_v_reg;
	logic [15:0] proc_reg;
	logic [ADC_W-1:0] a_cur_reg;
	logic [ADC_W-1:0] a_prev_reg;
	logic signed [ADC_W+15:0] prod;

	assign in_rdy = core_s.ready;
	assign s2 = proc_v_reg && in_rdy;
	assign prod = $signed(adc_data) * $signed(gain_reg);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			proc_v_reg <= 1'b0;
			proc_reg <= 16'h0;
			a_cur_reg <= '0;
			a_prev_reg <= '0;
		end else if (in_rdy) begin
			proc_v_reg <= adc_valid;
			if (adc_valid) begin
				proc_reg <= 16'(prod >>> `TSACQ_GAIN_FRAC) +
					offs_reg;
				a_cur_reg <= chan_a_data;
				a_prev_reg <= a_cur_reg;
			end
		end
	end

	logic [15:0] skip_cnt_reg;
	logic keep;

	assign keep = s2 && skip_cnt_reg == 16'h0;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			skip_cnt_reg <= 16'h0;
		end else if (s2) begin
			skip_cnt_reg <= (skip_cnt_reg + 16'h1 >= skip_reg) ?
				16'h0 : skip_cnt_reg + 16'h1;
		end
	end

	// Trigger detection
	logic above_reg;
	logic above;
	logic lvl_hit;
	logic a_hit;
	logic sync_prev_reg;
	logic sync_rise;
	logic bp_prev_reg;
	logic ext_pend_reg;
	logic sync_pend_reg;
	logic sw_pend_reg;
	logic trig;
	logic accept;
	tsacq_src_t src;
	tsacq_sync_t smode;

	assign src = tsacq_src_t'(ctrl_reg[`TSACQ_CTRL_SRC]);
	assign smode = tsacq_sync_t'(ctrl_reg[`TSACQ_CTRL_SYNC]);
	assign above = $signed(proc_reg) > $signed(level_reg);
	assign lvl_hit = ctrl_reg[`TSACQ_CTRL_FALL] ?
		(above_reg && !above) : (!above_reg && above);
	assign a_hit = s2 && $signed(a_prev_reg) < $signed(extlvl_reg[9:0]) &&
		$signed(a_cur_reg) >= $signed(extlvl_reg[9:0]);
	assign sync_rise = sync_i && !sync_prev_reg;
	assign trig = sw_pend_reg || (src == TSACQ_SRC_EXT && ext_pend_reg) ||
		(src == TSACQ_SRC_LEVEL && lvl_hit) ||
		(src == TSACQ_SRC_SYNC && sync_pend_reg);
	assign accept = keep && st_reg == TSACQ_ARMED && trig;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			above_reg <= 1'b0;
		end else if (keep) begin
			above_reg <= above;
		end
	end

	// Pending flags: a new event wins over consumption in the same cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_prev_reg <= 1'b0;
			bp_prev_reg <= 1'b0;
			ext_pend_reg <= 1'b0;
			sync_pend_reg <= 1'b0;
			sw_pend_reg <= 1'b0;
		end else begin
			sync_prev_reg <= sync_i;
			bp_prev_reg <= bp_trig;
			ext_pend_reg <= (ctrl_reg[`TSACQ_CTRL_EXTBP] ?
				(bp_trig && !bp_prev_reg) : a_hit) ||
				(ext_pend_reg && !keep);
			sync_pend_reg <= (sync_rise && smode == TSACQ_SYNC_CHAIN) ||
				(sync_pend_reg && !keep);
			sw_pend_reg <= (cmd_wr && pwdata[`TSACQ_CMD_SWTRIG]) ||
				(sw_pend_reg && !keep);
		end
	end

	// Time-stamp counter and trigger latch
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ts_reg <= '0;
			ts_lat_reg <= '0;
		end else begin
			if (smode == TSACQ_SYNC_TSRST && sync_rise) begin
				ts_reg <= '0;
			end else begin
				ts_reg <= ts_reg + 1'b1;
			end
			if (accept) begin
				ts_lat_reg <= ts_reg;
			end
		end
	end

	// Sync pin drive
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_o <= 1'b0;
			sync_oe <= 1'b0;
		end else begin
			case (smode)
				TSACQ_SYNC_DRIVE: begin
					sync_oe <= 1'b1;
					sync_o <= accept;
				end
				TSACQ_SYNC_CHAIN: begin
					sync_oe <= 1'b1;
					sync_o <= sync_i || accept;
				end
				default: begin
					sync_oe <= 1'b0;
					sync_o <= 1'b0;
				end
			endcase
		end
	end

	// Sub-sample crossing time on channel A, restoring divider
	logic [19:0] div_num_reg;
	logic [11:0] div_rem_reg;
	logic [10:0] div_den_reg;
	logic [19:0] div_quo_reg;
	logic [4:0] div_cnt_reg;
	logic div_busy_reg;
	logic [12:0] div_try;
	logic [11:0] div_sh;
	logic [10:0] a_num;
	logic [10:0] a_den;

	assign a_num = 11'($signed(extlvl_reg[9:0]) - $signed(a_prev_reg));
	assign a_den = 11'($signed(a_cur_reg) - $signed(a_prev_reg));
	assign div_sh = {div_rem_reg[10:0], div_num_reg[19]};
	assign div_try = {1'b0, div_sh} - {2'b0, div_den_reg};

	logic [10:0] hit_num_reg;
	logic [10:0] hit_den_reg;

	// Crossing pair is held until the next channel A crossing replaces it
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hit_num_reg <= 11'h0;
			hit_den_reg <= 11'h0;
		end else if (a_hit) begin
			hit_num_reg <= a_num;
			hit_den_reg <= a_den;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_num_reg <= 20'h0;
			div_rem_reg <= 12'h0;
			div_den_reg <= 11'h0;
			div_quo_reg <= 20'h0;
			div_cnt_reg <= 5'h0;
			div_busy_reg <= 1'b0;
			frac_reg <= 9'h0;
		end else if (div_busy_reg) begin
			div_num_reg <= {div_num_reg[18:0], 1'b0};
			div_rem_reg <= div_try[12] ? div_sh : div_try[11:0];
			div_quo_reg <= {div_quo_reg[18:0], !div_try[12]};
			div_cnt_reg <= div_cnt_reg - 5'h1;
			if (div_cnt_reg == 5'h1) begin
				div_busy_reg <= 1'b0;
				frac_reg <= {div_quo_reg[7:0], !div_try[12]};
			end
		end else if (accept && src == TSACQ_SRC_EXT &&
			!ctrl_reg[`TSACQ_CTRL_EXTBP]) begin
			div_num_reg <= 20'(hit_num_reg * `TSACQ_INTERP_STEPS);
			div_den_reg <= hit_den_reg;
			div_rem_reg <= 12'h0;
			div_quo_reg <= 20'h0;
			div_cnt_reg <= 5'h14;
			div_busy_reg <= 1'b1;
		end
	end

	// Pre-trigger history in flip-flops
	logic [15:0] hist [PRE_DEPTH];
	logic [AW-1:0] wp_reg;
	logic [15:0] pre_eff;
	logic [15:0] word;

	assign pre_eff = (pre_reg > len_reg) ? len_reg : pre_reg;
	assign word = (pre_eff == 16'h0) ? proc_reg :
		hist[wp_reg - AW'(pre_eff)];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_reg <= '0;
		end else if (keep) begin
			wp_reg <= wp_reg + 1'b1;
		end
	end

	for (genvar i = 0; i < PRE_DEPTH; i++) begin : g_hist
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				hist[i] <= 16'h0;
			end else if (keep && wp_reg == AW'(i)) begin
				hist[i] <= proc_reg;
			end
		end
	end

	// Record sequencing
	logic [15:0] cnt_reg;
	logic [15:0] dcnt_reg;
	logic push;
	logic rec_end;
	logic [15:0] cnt_base;

	assign push = keep && (st_reg == TSACQ_CAPT ||
		(st_reg == TSACQ_DELAY && dcnt_reg == dly_reg) ||
		(accept && dly_reg == 16'h0));
	assign cnt_base = (st_reg == TSACQ_CAPT) ? cnt_reg : 16'h0;
	assign rec_end = cnt_base + 16'h1 >= len_reg;
	assign core_s.valid = push;
	assign core_s.data = {cnt_base == 16'h0, rec_end, word};

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= TSACQ_IDLE;
			cnt_reg <= 16'h0;
			dcnt_reg <= 16'h0;
			done_reg <= 16'h0;
		end else if (cmd_wr && pwdata[`TSACQ_CMD_STOP]) begin
			st_reg <= TSACQ_IDLE;
		end else if (st_reg == TSACQ_IDLE) begin
			if (cmd_wr && pwdata[`TSACQ_CMD_ARM]) begin
				st_reg <= TSACQ_ARMED;
				done_reg <= 16'h0;
			end
		end else if (push && rec_end) begin
			done_reg <= done_reg + 16'h1;
			if (nrec_reg != 16'h0 && done_reg + 16'h1 >= nrec_reg) begin
				st_reg <= TSACQ_IDLE;
			end else begin
				st_reg <= TSACQ_ARMED;
			end
		end else if (push) begin
			st_reg <= TSACQ_CAPT;
			cnt_reg <= cnt_base + 16'h1;
		end else if (accept) begin
			st_reg <= TSACQ_DELAY;
			dcnt_reg <= 16'h1;
		end else if (keep && st_reg == TSACQ_DELAY) begin
			dcnt_reg <= dcnt_reg + 16'h1;
		end
	end

	tsacq_buf #(.W(18)) u_buf (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.in_s(core_s),
		.out_s(out_s)
	);

	assign out_s.ready = rec_ready;
	assign rec_data = out_s.data[15:0];
	assign rec_last = out_s.data[16];
	assign rec_first = out_s.data[17];
	assign rec_valid = out_s.valid;
	assign adc_ready = in_rdy;
endmodule : tsacq_top

// ---- rtl/tsacq_map.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef TSACQ_MAP_SVH
`define TSACQ_MAP_SVH
`define TSACQ_CTRL_OFS 8'h00
`define TSACQ_LEVEL_OFS 8'h04
`define TSACQ_EXTLVL_OFS 8'h08
`define TSACQ_GAIN_OFS 8'h0c
`define TSACQ_OFFS_OFS 8'h10
`define TSACQ_PRE_OFS 8'h14
`define TSACQ_DLY_OFS 8'h18
`define TSACQ_LEN_OFS 8'h1c
`define TSACQ_NREC_OFS 8'h20
`define TSACQ_SKIP_OFS 8'h24
`define TSACQ_STAT_OFS 8'h28
`define TSACQ_TSLO_OFS 8'h2c
`define TSACQ_TSHI_OFS 8'h30
`define TSACQ_FRAC_OFS 8'h34
`define TSACQ_CMD_OFS 8'h38
`define TSACQ_CTRL_SRC 1:0
`define TSACQ_CTRL_EXTBP 2
`define TSACQ_CTRL_FALL 3
`define TSACQ_CTRL_SYNC 5:4
`define TSACQ_CTRL_REF 7:6
`define TSACQ_CMD_ARM 0
`define TSACQ_CMD_SWTRIG 1
`define TSACQ_CMD_STOP 2
`define TSACQ_STAT_BUSY 0
`define TSACQ_STAT_LOCK 1
`define TSACQ_STAT_CNT 31:16
`define TSACQ_GAIN_RST 16'h1000
`define TSACQ_GAIN_FRAC 12
`define TSACQ_LEN_RST 16'h0100
`define TSACQ_TRIG_RES_PS 25
`define TSACQ_SAMPLE_PS 8000
`define TSACQ_INTERP_STEPS (`TSACQ_SAMPLE_PS / `TSACQ_TRIG_RES_PS)
`endif

// ---- rtl/tsacq_pkg.sv ----
// Types shared by the acquisition modules
package tsacq_pkg;
	typedef enum logic [3:0] {
		TSACQ_IDLE = 4'b0001,
		TSACQ_ARMED = 4'b0010,
		TSACQ_DELAY = 4'b0100,
		TSACQ_CAPT = 4'b1000
	} tsacq_state_t;
	typedef enum logic [1:0] {
		TSACQ_SRC_SW = 2'h0,
		TSACQ_SRC_EXT = 2'h1,
		TSACQ_SRC_LEVEL = 2'h2,
		TSACQ_SRC_SYNC = 2'h3
	} tsacq_src_t;
	typedef enum logic [1:0] {
		TSACQ_SYNC_HIZ = 2'h0,
		TSACQ_SYNC_TSRST = 2'h1,
		TSACQ_SYNC_DRIVE = 2'h2,
		TSACQ_SYNC_CHAIN = 2'h3
	} tsacq_sync_t;
endpackage : tsacq_pkg

// ---- rtl/tsacq_strm_if.sv ----
// Record word stream between acquisition core and output buffer
`timescale 1ns/1ps
interface tsacq_strm_if #(parameter int W = 18);
	logic [W-1:0] data;
	logic valid;
	logic ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : tsacq_strm_if

// ---- rtl/tsacq_buf.sv ----
// Two-entry buffer with registered outputs and registered ready
`timescale 1ns/1ps
module tsacq_buf #(
	parameter int W = 18
) (
	input wire logic core_clk,
	input wire logic rst_n,
	tsacq_strm_if.snk in_s,
	tsacq_strm_if.src out_s
);
	logic [W-1:0] out_reg;
	logic [W-1:0] skid_reg;
	logic out_v_reg;
	logic skid_v_reg;
	logic rdy_reg;
	logic push;

	assign push = in_s.valid && rdy_reg;
	assign in_s.ready = rdy_reg;
	assign out_s.data = out_reg;
	assign out_s.valid = out_v_reg;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_reg <= '0;
			skid_reg <= '0;
			out_v_reg <= 1'b0;
			skid_v_reg <= 1'b0;
			rdy_reg <= 1'b0;
		end else if (!out_v_reg || out_s.ready) begin
			if (skid_v_reg) begin
				out_reg <= skid_reg;
				out_v_reg <= 1'b1;
				skid_v_reg <= 1'b0;
			end else begin
				out_reg <= in_s.data;
				out_v_reg <= push;
			end
			rdy_reg <= 1'b1;
		end else if (push) begin
			// Receiver stalls: the second entry keeps the word
			skid_reg <= in_s.data;
			skid_v_reg <= 1'b1;
			rdy_reg <= 1'b0;
		end else begin
			rdy_reg <= !skid_v_reg;
		end
	end
endmodule : tsacq_buf

// ---- tb/tsacq_top_asserts.sv ----
// Port-level assertions for the acquisition block
`timescale 1ns/1ps
module tsacq_top_asserts (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic adc_ready,
	input wire logic sync_o,
	input wire logic sync_oe,
	input wire logic [1:0] ref_sel,
	input wire logic [15:0] rec_data,
	input wire logic rec_first,
	input wire logic rec_last,
	input wire logic rec_valid,
	input wire logic rec_ready
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic wr_ctrl;
	assign wr_ctrl = psel && penable && pwrite && paddr == 8'h00;
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence access_s;
		psel && penable && pready;
	endsequence
	a_apb_answer: assert property (setup_s |=> access_s)
		else $error("apb access not answered after setup");
	a_pready_single: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	a_pready_cause: assert property (pready |-> $past(psel && !penable))
		else $error("pready without a setup cycle");
	a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error response with data or without pready");
	a_rec_hold: assert property (
		rec_valid && !rec_ready |=> rec_valid
		&& $stable({rec_data, rec_first, rec_last}))
		else $error("record word changed while stalled");
	a_no_free_stall: assert property (rec_ready [*3] |-> adc_ready)
		else $error("sample input stalled with receiver ready");
	a_sync_oe_drive: assert property (sync_o |-> sync_oe)
		else $error("sync level without output enable");
	a_ref_follow: assert property (
		$changed(ref_sel) |-> $past(wr_ctrl, 2) || $past(wr_ctrl, 3))
		else $error("reference select moved without a control write");
endmodule : tsacq_top_asserts
bind tsacq_top tsacq_top_asserts u_asserts (.core_clk, .rst_n, .psel,
	.penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .adc_ready,
	.sync_o, .sync_oe, .ref_sel, .rec_data, .rec_first, .rec_last,
	.rec_valid, .rec_ready);

// ---- tb/tsacq_fe_model.sv ----
// Front-end model: sample ramp, channel A copy, upstream sync line
`timescale 1ns/1ps
module tsacq_fe_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic adc_ready,
	input wire logic slow,
	input wire logic pulse_drv,
	input wire logic pulse_oe,
	output logic [9:0] adc_data,
	output logic [9:0] chan_a_data,
	output logic adc_valid,
	output logic sync_i
);
	logic [7:0] ramp_reg;
	logic gap_reg;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ramp_reg <= 8'h00;
		end else if (adc_valid && adc_ready) begin
			ramp_reg <= ramp_reg + 8'h01;
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_reg <= 1'b0;
		end else begin
			gap_reg <= slow && !gap_reg;
		end
	end
	assign adc_valid = !gap_reg;
	// Idle cycles carry inverted data so a stale word cannot pass
	assign adc_data = adc_valid ? {2'b00, ramp_reg} : ~{2'b00, ramp_reg};
	assign chan_a_data = adc_data;
	// Line pulled low whenever the upstream unit releases it
	assign sync_i = pulse_oe ? pulse_drv : 1'b0;
endmodule : tsacq_fe_model

// ---- tb/tb_trigger_timestamp_acquisition.sv ----
// Self-checking bench for the acquisition block
`timescale 1ns/1ps
`include "tsacq_map.svh"
module tb_trigger_timestamp_acquisition;
	logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [9:0] adc_data, chan_a_data;
	logic adc_valid, adc_ready, bp_trig, sync_i, sync_o, sync_oe;
	logic pll_locked, rec_first, rec_last, rec_valid, rec_ready;
	logic slow, pulse_drv, pulse_oe, so_d;
	logic [1:0] ref_sel;
	logic [15:0] rec_data;
	logic [15:0] w [4];
	int err_count, total_checks, npulse, n0, x0, stl;
	tsacq_top uut (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .adc_data, .chan_a_data,
		.adc_valid, .adc_ready, .bp_trig, .sync_i, .sync_o, .sync_oe,
		.ref_sel, .pll_locked, .rec_data, .rec_first, .rec_last,
		.rec_valid, .rec_ready);
	tsacq_fe_model u_fe (.core_clk, .rst_n, .adc_ready, .slow, .pulse_drv,
		.pulse_oe, .adc_data, .chan_a_data, .adc_valid, .sync_i);
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		so_d <= sync_o && sync_oe;
		if (sync_o && sync_oe && !so_d) npulse++;
	end
	task end_of_test;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= we;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge core_clk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			err_count++;
			end_of_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask : rchk
	task run(input logic [31:0] c, p, d, n);
		wr(`TSACQ_CTRL_OFS, c);
		wr(`TSACQ_PRE_OFS, p);
		wr(`TSACQ_DLY_OFS, d);
		wr(`TSACQ_NREC_OFS, n);
		wr(`TSACQ_CMD_OFS, 32'h1);
	endtask : run
	task cap;
		int i, k;
		k = 0;
		for (i = 0; i < 3000 && k < 4; i++) begin
			@(posedge core_clk);
			if (rec_valid === 1'b1 && rec_ready === 1'b1) begin
				chk("first", k == 0, rec_first);
				chk("last", k == 3, rec_last);
				w[k] = rec_data;
				k++;
			end
			rec_ready <= stl ? i[1] : 1'b1;
		end
		if (k < 4) begin
			err_count++;
			end_of_test();
		end
	endtask : cap
	task seq(input logic [7:0] st);
		logic [7:0] dd;
		for (int i = 1; i < 4; i++) begin
			dd = w[i][7:0] - w[i-1][7:0];
			chk("step", st, dd);
		end
	endtask : seq
	task pin_pulse;
		@(posedge core_clk);
		pulse_oe <= 1'b1;
		pulse_drv <= 1'b1;
		repeat (2) @(posedge core_clk);
		pulse_oe <= 1'b0;
		pulse_drv <= 1'b0;
	endtask : pin_pulse
	initial begin
		err_count = 0;
		total_checks = 0;
		npulse = 0;
		stl = 0;
		rst_n = 1'b0;
		{psel, penable, pwrite, bp_trig, slow, pulse_drv, pulse_oe} = 7'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pll_locked = 1'b1;
		rec_ready = 1'b1;
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		rchk("gain", `TSACQ_GAIN_OFS, 32'h1000);
		rchk("len", `TSACQ_LEN_OFS, 32'h100);
		rchk("stat", `TSACQ_STAT_OFS, 32'h2);
		rchk("cmd", `TSACQ_CMD_OFS, 32'h0);
		rchk("unmapped", 8'h3c, 32'h0);
		chk("slverr", 1, er);
		wr(`TSACQ_CTRL_OFS, 32'h80);
		repeat (2) @(posedge core_clk);
		chk("ref", 2, ref_sel);
		wr(`TSACQ_LEVEL_OFS, 32'd100);
		wr(`TSACQ_LEN_OFS, 32'd4);
		run(32'h2, 0, 0, 2);
		cap();
		x0 = w[0];
		seq(8'd1);
		chk("cross", 32'h65, w[0]);
		xfer(1'b0, `TSACQ_TSLO_OFS, 32'h0);
		n0 = rd;
		cap();
		chk("rearm", x0, w[0]);
		rchk("ts", `TSACQ_TSLO_OFS, (n0 + 256) & 32'hffff);
		rchk("stat2", `TSACQ_STAT_OFS, 32'h00020002);
		run(32'h2, 4, 0, 1);
		cap();
		chk("pre", x0 - 4, w[0]);
		chk("pre_end", x0 - 1, w[3]);
		run(32'h2, 0, 5, 1);
		cap();
		chk("delay", x0 + 5, w[0]);
		run(32'ha, 0, 0, 1);
		cap();
		chk("fall", 0, w[0]);
		wr(`TSACQ_GAIN_OFS, 32'h2000);
		wr(`TSACQ_OFFS_OFS, 32'd7);
		wr(`TSACQ_SKIP_OFS, 32'd3);
		run(32'h2, 0, 0, 1);
		cap();
		seq(8'd6);
		chk("odd", 1, w[0][0]);
		wr(`TSACQ_GAIN_OFS, 32'h1000);
		wr(`TSACQ_OFFS_OFS, 32'd0);
		wr(`TSACQ_SKIP_OFS, 32'd0);
		stl = 1;
		slow <= 1'b1;
		n0 = npulse;
		run(32'h20, 0, 0, 1);
		wr(`TSACQ_CMD_OFS, 32'h2);
		cap();
		seq(8'd1);
		chk("drive", n0 + 1, npulse);
		stl = 0;
		slow <= 1'b0;
		run(32'h0, 0, 0, 1);
		wr(`TSACQ_CMD_OFS, 32'h2);
		cap();
		chk("hiz", n0 + 1, npulse);
		chk("hiz_oe", 0, sync_oe);
		run(32'h10, 0, 0, 1);
		pin_pulse();
		wr(`TSACQ_CMD_OFS, 32'h2);
		cap();
		xfer(1'b0, `TSACQ_TSLO_OFS, 32'h0);
		chk("ts_zero", 1, rd < 20);
		run(32'h33, 0, 0, 1);
		pin_pulse();
		cap();
		chk("chain", 1, npulse > n0 + 1);
		run(32'h5, 0, 0, 1);
		@(posedge core_clk);
		bp_trig <= 1'b1;
		repeat (2) @(posedge core_clk);
		bp_trig <= 1'b0;
		cap();
		wr(`TSACQ_EXTLVL_OFS, 32'd50);
		run(32'h1, 0, 0, 1);
		cap();
		chk("chan_a", 32'h33, w[0]);
		repeat (25) @(posedge core_clk);
		xfer(1'b0, `TSACQ_FRAC_OFS, 32'h0);
		chk("frac", `TSACQ_INTERP_STEPS, rd);
		run(32'h2, 0, 0, 0);
		cap();
		cap();
		wr(`TSACQ_CMD_OFS, 32'h4);
		xfer(1'b0, `TSACQ_STAT_OFS, 32'h0);
		chk("stopped", 0, rd[0]);
		pll_locked <= 1'b0;
		rchk("unlock", `TSACQ_STAT_OFS, 32'h00020000);
		end_of_test();
	end
endmodule : tb_trigger_timestamp_acquisition
